// ==== shared/dram_ctl_pkg.sv ====
// constants and types for the page-mode dram controller
// assumes a 20 MHz REF_CLK and an asynchronous 1M x 8 dram module outside
//
// Behaviour
// - page read: row held, column strobes, write high
// - page write: write low, data at strobe
// - all 512 rows refreshed every 8.2 ms
// - row-only refresh: column strobe held high
// - column-before-row refresh needs no row address
// - hidden refresh keeps column strobe low after read
// - hidden refresh must be column-before-row type
// - write select high reads, low writes
// - ten-bit row then column on shared pins
package dram_ctl_pkg;
  localparam int ADDR_W = 10; // multiplexed address width
  localparam int DATA_W = 8;  // module data width
  localparam int ROWS_REFRESH = 512; // refresh rows
  localparam int CLK_PERIOD_NS = 50; // REF_CLK period
  // access delays and write lead time in ns
  localparam int COLUMN_STROBE_ACCESS_TIME_NS = 35;
  localparam int COLUMN_ADDRESS_ACCESS_TIME_NS = 60;
  localparam int STROBE_PRECHARGE_ACCESS_TIME_NS = 70;
  localparam int WRITE_TO_STROBE_LEAD_TIME_NS = 25;
  // least times round up; page reads wait for the latest of three delays
  localparam int ACCESS_CA_NS = (COLUMN_STROBE_ACCESS_TIME_NS >
    COLUMN_ADDRESS_ACCESS_TIME_NS) ? COLUMN_STROBE_ACCESS_TIME_NS :
    COLUMN_ADDRESS_ACCESS_TIME_NS;
  localparam int ACCESS_NS = (ACCESS_CA_NS >
    STROBE_PRECHARGE_ACCESS_TIME_NS) ? ACCESS_CA_NS :
    STROBE_PRECHARGE_ACCESS_TIME_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_PRE_NS = 80; // row strobe precharge
  localparam int RAS_PRE_CYC = (RAS_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refresh interval: 8.2 ms over 512 rows, longest time rounds down
  localparam int REFRESH_PERIOD_US10 = 82; // 8.2 ms in 0.1 ms units
  localparam int REFRESH_STEP_CYC = (REFRESH_PERIOD_US10 * 100000 /
    CLK_PERIOD_NS) / ROWS_REFRESH;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1; // page column precharge length
  typedef enum logic [1:0] {
    CMD_READ, CMD_WRITE, CMD_ROW_REFRESH, CMD_CBR_REFRESH
  } cmd_t;
endpackage : dram_ctl_pkg

// ==== shared/dram_req_if.sv ====
// request interface between the controller and its refresh pacer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dram_req_if;
  logic due;  // refresh is owed
  logic done; // one refresh issued, pulse
  modport pacer (output due, input done);
  modport ctl   (input due, output done);
endinterface : dram_req_if

// ==== logic/refresh_pacer.sv ====
// refresh pacer: raises due once per refresh step
// assumes done pulses once per refresh issued
`timescale 1ns/1ps
module refresh_pacer #(
  parameter int STEP_CYC = dram_ctl_pkg::REFRESH_STEP_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  dram_req_if.pacer req
);
  typedef struct packed {
    logic [19:0] cnt; // cycles until next row is owed
    logic        due; // sticky owed flag
  } pace_t;
  pace_t cur;
  pace_t next_cur;
  // count down; set wins over the done clear so no step is lost
  always_comb begin
    next_cur = cur;
    if (req.done) begin
      next_cur.due = 1'b0;
    end
    if (cur.cnt == 20'h00000) begin
      next_cur.cnt = 20'(STEP_CYC - 1);
      next_cur.due = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt - 20'h00001;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign req.due = cur.due;
  // owed flag rises when counter wraps
  chk_pace_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    cur.cnt == 20'h00000 |=> req.due)
    else $error("refresh not owed after step");
endmodule : refresh_pacer

// ==== logic/dram_page_ctl.sv ====
// page-mode dram controller driving strobes, address and data pins
// assumes the dram answers asynchronously; DQ_IN is synchronised here
`timescale 1ns/1ps
module dram_page_ctl #(
  parameter int STEP_CYC = dram_ctl_pkg::REFRESH_STEP_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        REQ_VALID,   // user request
  input  wire logic [1:0]  REQ_CMD,     // dram_ctl_pkg::cmd_t
  input  wire logic [9:0]  REQ_ROW,
  input  wire logic [9:0]  REQ_COL,
  input  wire logic [7:0]  REQ_WDATA,
  input  wire logic        REQ_LAST,    // close row after this access
  input  wire logic        REQ_HIDDEN,  // keep column strobe into refresh after a read
  output logic             REQ_READY,
  output logic             RD_VALID,
  output logic [7:0]       RD_DATA,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic [9:0]       ADDR,
  input  wire logic [7:0]  DQ_IN,
  output logic [7:0]       DQ_OUT,
  output logic             DQ_OE
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_WAIT, ST_PRE, ST_CBR, ST_HOLD
  } state_t;
  typedef struct packed {
    state_t     st;
    logic [3:0] cnt;     // delay counter
    logic       open;    // a row is latched
    logic       hidden;  // column strobe stays low into refresh after a read
    logic       last;
    logic       wr;
    logic [9:0] row;
    logic [9:0] col;
    logic [8:0] rfr_row; // own row-only refresh row
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [9:0] addr;
    logic [7:0] dq_out;
    logic       dq_oe;
    logic       ready;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       done;
    logic [7:0] sync1;   // first synchroniser stage
    logic [7:0] sync2;   // second synchroniser stage
  } ctl_t;
  ctl_t cur;
  ctl_t next_cur;
  dram_req_if rif ();
  refresh_pacer #(.STEP_CYC(STEP_CYC)) u_pacer (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .req   (rif)
  );
  assign rif.done = cur.done;
  // true when a command is a refresh kind
  function automatic logic is_refresh(input logic [1:0] c);
    return c == dram_ctl_pkg::CMD_ROW_REFRESH ||
           c == dram_ctl_pkg::CMD_CBR_REFRESH;
  endfunction : is_refresh
  // main sequencer
  always_comb begin
    next_cur = cur;
    next_cur.sync1 = DQ_IN;
    next_cur.sync2 = cur.sync1;
    next_cur.rd_valid = 1'b0;
    next_cur.done = 1'b0;
    next_cur.ready = 1'b0;
    case (cur.st)
      ST_IDLE: begin
        // both strobes high: standby
        next_cur.ras_n = 1'b1;
        next_cur.dq_oe = 1'b0;
        if (REQ_VALID && cur.ready) begin
          // a request shown ready is always taken; an owed refresh
          // that rose meanwhile waits, else the request would be lost
          if (REQ_CMD == dram_ctl_pkg::CMD_CBR_REFRESH) begin
            next_cur.cas_n = 1'b0;
            next_cur.st = ST_CBR;
          end else if (is_refresh(REQ_CMD)) begin
            next_cur.addr = REQ_ROW;
            next_cur.cas_n = 1'b1;
            next_cur.ras_n = 1'b0;
            next_cur.cnt = 4'(dram_ctl_pkg::ACCESS_CYC + 1);
            next_cur.st = ST_PRE;
          end else begin
            next_cur.cas_n = 1'b1;
            next_cur.addr = REQ_ROW;
            next_cur.row = REQ_ROW;
            next_cur.col = REQ_COL;
            next_cur.wr = REQ_CMD == dram_ctl_pkg::CMD_WRITE;
            next_cur.last = REQ_LAST;
            next_cur.hidden = REQ_HIDDEN;
            next_cur.dq_out = REQ_WDATA;
            next_cur.st = ST_ROW;
          end
        end else if (rif.due) begin
          // pacer refresh, row-only with own counter
          next_cur.addr = {1'b0, cur.rfr_row};
          next_cur.rfr_row = cur.rfr_row + 9'h001;
          next_cur.cas_n = 1'b1;
          next_cur.ras_n = 1'b0;
          next_cur.cnt = 4'(dram_ctl_pkg::ACCESS_CYC + 1);
          next_cur.st = ST_PRE;
          next_cur.done = 1'b1;
        end else if (REQ_VALID) begin
          // no refresh owed: offer to take the request next edge
          next_cur.ready = 1'b1;
        end
      end
      ST_ROW: begin
        // row latched on fall, then column on same pins
        next_cur.ras_n = 1'b0;
        next_cur.open = 1'b1;
        next_cur.st = ST_COL;
      end
      ST_COL: begin
        next_cur.addr = cur.col;
        next_cur.we_n = !cur.wr;
        next_cur.dq_oe = cur.wr;
        next_cur.st = ST_WAIT;
        next_cur.cnt = 4'(dram_ctl_pkg::ACCESS_CYC + 2);
      end
      ST_WAIT: begin
        // column strobe falls; write data latched at that edge
        next_cur.cas_n = 1'b0;
        if (cur.cnt != dram_ctl_pkg::CNT_ZERO) begin
          next_cur.cnt = cur.cnt - 4'h1;
        end else begin
          // sample after latest access delay plus sync stages
          if (!cur.wr) begin
            next_cur.rd_data = cur.sync2;
            next_cur.rd_valid = 1'b1;
          end
          next_cur.we_n = 1'b1;
          if (cur.hidden && !cur.wr) begin
            // keep column low, lift row for a hidden refresh
            next_cur.ras_n = 1'b1;
            next_cur.cnt = 4'(dram_ctl_pkg::RAS_PRE_CYC);
            next_cur.st = ST_HOLD;
          end else if (cur.last || rif.due) begin
            next_cur.cas_n = 1'b1;
            next_cur.ras_n = 1'b1;
            next_cur.dq_oe = 1'b0;
            next_cur.open = 1'b0;
            next_cur.cnt = 4'(dram_ctl_pkg::RAS_PRE_CYC);
            next_cur.st = ST_PRE;
          end else begin
            next_cur.cas_n = 1'b1; // precharge before next column
            next_cur.dq_oe = 1'b0;
            next_cur.st = ST_PRE;
            next_cur.cnt = dram_ctl_pkg::CNT_ONE;
          end
        end
      end
      ST_PRE: begin
        // precharge, or hold an open row for the next page column
        if (cur.cnt != dram_ctl_pkg::CNT_ZERO) begin
          next_cur.cnt = cur.cnt - 4'h1;
        end else if (cur.open && cur.ready && REQ_VALID &&
                     !is_refresh(REQ_CMD)) begin
          // page column, row not re-latched
          next_cur.col = REQ_COL;
          next_cur.wr = REQ_CMD == dram_ctl_pkg::CMD_WRITE;
          next_cur.last = REQ_LAST;
          next_cur.hidden = REQ_HIDDEN;
          next_cur.dq_out = REQ_WDATA;
          next_cur.st = ST_COL;
        end else if (cur.open && (rif.due || (REQ_VALID &&
                     (is_refresh(REQ_CMD) || REQ_ROW != cur.row)))) begin
          // close: refresh owed, refresh asked, or another row wanted
          next_cur.ras_n = 1'b1;
          next_cur.open = 1'b0;
          next_cur.cnt = 4'(dram_ctl_pkg::RAS_PRE_CYC);
        end else if (cur.open) begin
          // row stays latched; the owed refresh bounds how long
          next_cur.ready = REQ_VALID && REQ_ROW == cur.row;
        end else begin
          next_cur.ras_n = 1'b1;
          next_cur.cas_n = 1'b1;
          next_cur.dq_oe = 1'b0;
          next_cur.st = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // column stays low from the read, so refresh is cbr type
        if (cur.cnt != dram_ctl_pkg::CNT_ZERO) begin
          next_cur.cnt = cur.cnt - 4'h1;
        end else begin
          next_cur.ras_n = 1'b0;
          next_cur.open = 1'b0;
          next_cur.hidden = 1'b0;
          next_cur.cnt = 4'(dram_ctl_pkg::ACCESS_CYC + 1);
          next_cur.st = ST_PRE;
        end
      end
      ST_CBR: begin
        // device supplies and advances its own row
        next_cur.ras_n = 1'b0;
        next_cur.cnt = 4'(dram_ctl_pkg::ACCESS_CYC + 1);
        next_cur.st = ST_PRE;
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cur <= '{st: ST_IDLE, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
               default: '0};
    end else begin
      cur <= next_cur;
    end
  end
  assign REQ_READY = cur.ready;
  assign RD_VALID  = cur.rd_valid;
  assign RD_DATA   = cur.rd_data;
  assign RAS_N     = cur.ras_n;
  assign CAS_N     = cur.cas_n;
  assign WE_N      = cur.we_n;
  assign ADDR      = cur.addr;
  assign DQ_OUT    = cur.dq_out;
  assign DQ_OE     = cur.dq_oe;
  // column fall after row fall in a normal read
  sequence s_row_open;
    $fell(RAS_N) && CAS_N && cur.st == ST_COL;
  endsequence
  chk_row_then_col: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_row_open ##1 !RAS_N |-> ##[1:2] $fell(CAS_N) || RAS_N)
    else $error("column strobe did not follow row");
  chk_no_drive_row: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (!RAS_N && CAS_N && cur.st == ST_PRE && !cur.open) |-> !DQ_OE)
    else $error("data driven in row-only refresh");
  chk_write_sel: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ($fell(CAS_N) && DQ_OE) |-> !WE_N)
    else $error("write data without write select");
  chk_standby: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (cur.st == ST_IDLE && RAS_N && CAS_N) |-> !DQ_OE)
    else $error("driving in standby");
  chk_read_wait: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $fell(CAS_N) && WE_N |-> !RD_VALID [*2])
    else $error("read sampled too early");
  chk_hidden_cas: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    cur.st == ST_HOLD |-> !CAS_N)
    else $error("column strobe rose in hidden refresh");
  chk_cbr_order: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    cur.st == ST_CBR |=> !RAS_N && !CAS_N)
    else $error("cbr ordering wrong");
  chk_page_row: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    cur.open && cur.st == ST_COL |-> !RAS_N)
    else $error("row closed during page column");
endmodule : dram_page_ctl

// ==== test/dram_module_model.sv ====
// behavioural 1M x 8 page-mode dram module answering the controller
// assumes strobes and data come from the controller; no pull on the lines
`timescale 1ns/1ps
module dram_module_model (
  input  wire logic       ras_n,  // row strobe, active low
  input  wire logic       cas_n,  // column strobe, active low
  input  wire logic       we_n,   // low selects write
  input  wire logic [9:0] addr,   // shared row and column address
  input  wire logic [7:0] ctl_q,  // controller data out
  input  wire logic       ctl_oe, // controller drives the data lines
  input  wire logic       slow,   // answer reads late
  output logic      [7:0] dq      // resolved data lines
);
  logic [7:0]   mem [logic [19:0]];  // sparse cells, unwritten read 00
  logic [9:0]   row = 10'h000;       // latched row
  logic [8:0]   cbr_row = 9'h000;    // internal refresh row counter
  logic [511:0] fresh = '0;          // rows refreshed since cleared
  logic [7:0]   q = 8'h00;           // byte being read
  logic [7:0]   last = 8'h00;        // last value on the lines
  logic         drv = 1'b0;          // device drives data
  logic         cbr = 1'b0;          // cycle uses the internal row
  logic         col_seen = 1'b0;     // a column strobe came in this row
  logic [9:0]   last_ror = 10'h000;  // row of last row-only refresh
  int           cbr_cnt = 0;         // internal-row refreshes done
  int           clash = 0;           // both parties driving at once
  // released lines show the inverse of the last value, not a held copy
  assign dq = drv ? q : (ctl_oe ? ctl_q : ~last);
  always @(negedge drv) last = q;
  always @(negedge ctl_oe) last = ctl_q;
  // a clash here would show a controller that drives during a read
  always @(posedge drv or posedge ctl_oe) if (drv && ctl_oe) clash++;
  // row strobe fall: column strobe already low picks the internal row
  always @(negedge ras_n) begin
    col_seen = 1'b0;
    cbr = !cas_n;
    if (cbr) begin
      fresh[cbr_row] = 1'b1;
      cbr_cnt++;
    end else begin
      row = addr;
      fresh[addr[8:0]] = 1'b1;
    end
  end
  // row strobe rise closes the cycle; standby refreshes nothing
  always @(posedge ras_n) begin
    if (cbr) cbr_row++;
    else if (!col_seen) last_ror = row;
  end
  // column strobe fall in an open row: latch a write or time a read
  always @(negedge cas_n) if (!ras_n && !cbr) begin
    col_seen = 1'b1;
    if (!we_n) mem[{row, addr}] = ctl_q;
    else begin
      q = mem.exists({row, addr}) ? mem[{row, addr}] : 8'h00;
      #(slow ? 70 : 35);
      drv = !cas_n;
    end
  end
  // column strobe rise ends the output
  always @(posedge cas_n) drv = 1'b0;
endmodule : dram_module_model

// ==== test/test_dram_module_page_and_refresh.sv ====
// self-checking bench for the page-mode dram controller
// assumes the behavioural dram model on the far side of the pins
`timescale 1ns/1ps
module test_dram_module_page_and_refresh;
  localparam int STEP = 40; // short refresh step keeps the run brief
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       req_valid = 1'b0;
  logic [1:0] req_cmd = 2'h0;
  logic [9:0] req_row = 10'h000;
  logic [9:0] req_col = 10'h000;
  logic [7:0] req_wdata = 8'h00;
  logic       req_last = 1'b0;
  logic       req_hidden = 1'b0;
  logic       slow = 1'b0;
  logic       req_ready, rd_valid, ras_n, cas_n, we_n, dq_oe;
  logic [7:0] rd_data, dq, dq_out;
  logic [9:0] addr;
  int         n_fail = 0;
  int         n_compared = 0;
  int         cycles = 0;
  dram_page_ctl #(.STEP_CYC(STEP)) uut (.REF_CLK(ref_clk), .RST_B(rst_b),
    .REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_ROW(req_row),
    .REQ_COL(req_col), .REQ_WDATA(req_wdata), .REQ_LAST(req_last),
    .REQ_HIDDEN(req_hidden), .REQ_READY(req_ready), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
    .ADDR(addr), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
  dram_module_model mdl (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .ctl_q(dq_out), .ctl_oe(dq_oe), .slow(slow), .dq(dq));
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      report_and_stop;
    end
  end
  // compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask : check
  // present one request and hold it until the controller takes it
  task automatic issue(input logic [1:0] cmd, input logic [9:0] row,
      input logic [9:0] col, input logic [7:0] wd, input logic last,
      input logic hid);
    int i;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_row <= row;
    req_col <= col;
    req_wdata <= wd;
    req_last <= last;
    req_hidden <= hid;
    for (i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    check(32'(i < 400), 32'h1, "request taken");
    req_valid <= 1'b0;
  endtask : issue
  // wait for the read pulse and judge its byte and width
  task automatic expect_read(input logic [7:0] exp);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (rd_valid === 1'b1) break;
    end
    check(32'(rd_valid), 32'h1, "read pulse seen");
    check(32'(rd_data), 32'(exp), "read data");
    @(posedge ref_clk);
    check(32'(rd_valid), 32'h0, "read pulse width");
  endtask : expect_read
  // wait for one full row strobe cycle
  task automatic wait_ras;
    int i;
    for (i = 0; i < 60 && ras_n !== 1'b0; i++) @(posedge ref_clk);
    for (i = 0; i < 60 && ras_n !== 1'b1; i++) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask : wait_ras
  // strobes idle and data released while reset holds
  task automatic t_reset;
    repeat (16) @(posedge ref_clk);
    check(32'({ras_n, cas_n, dq_oe}), 32'h6, "reset pins");
    rst_b <= 1'b1;
  endtask : t_reset
  // page writes to end and alternating-bit columns, then page reads of the same row
  task automatic t_page;
    logic [9:0] cols [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    for (int k = 0; k < 4; k++)
      issue(dram_ctl_pkg::CMD_WRITE, 10'h2A5, cols[k], 8'hC3 ^ 8'(k),
        k == 3, 1'b0);
    check(32'(mdl.mem[{10'h2A5, 10'h3FF}]), 32'hC2, "stored");
    for (int k = 0; k < 4; k++) begin
      issue(dram_ctl_pkg::CMD_READ, 10'h2A5, cols[k], 8'h00, k == 3, 1'b0);
      expect_read(8'hC3 ^ 8'(k));
    end
  endtask : t_page
  // rows that differ only in the top bit hold separate bytes
  task automatic t_top_row_bit;
    issue(dram_ctl_pkg::CMD_WRITE, 10'h005, 10'h007, 8'hA1, 1'b1, 1'b0);
    issue(dram_ctl_pkg::CMD_WRITE, 10'h205, 10'h007, 8'h5E, 1'b1, 1'b0);
    slow <= 1'b1;
    issue(dram_ctl_pkg::CMD_READ, 10'h005, 10'h007, 8'h00, 1'b1, 1'b0);
    expect_read(8'hA1);
    issue(dram_ctl_pkg::CMD_READ, 10'h205, 10'h007, 8'h00, 1'b1, 1'b0);
    expect_read(8'h5E);
    slow <= 1'b0;
  endtask : t_top_row_bit
  // row-only refresh of a given row, then an internal-row refresh
  task automatic t_refresh;
    int n;
    logic [8:0] r;
    issue(dram_ctl_pkg::CMD_ROW_REFRESH, 10'h3F3, 10'h000, 8'h00, 1'b1,
      1'b0);
    wait_ras;
    check(32'(mdl.last_ror[8:0]), 32'h1F3, "row refreshed");
    n = mdl.cbr_cnt;
    r = mdl.cbr_row;
    issue(dram_ctl_pkg::CMD_CBR_REFRESH, 10'h000, 10'h000, 8'h00, 1'b1,
      1'b0);
    wait_ras;
    check(mdl.cbr_cnt, n + 1, "internal refresh count");
    check(32'(mdl.cbr_row), 32'(r + 9'h001), "refresh counter");
  endtask : t_refresh
  // read with column strobe kept low into an internal-row refresh
  task automatic t_hidden;
    int n;
    int i;
    issue(dram_ctl_pkg::CMD_WRITE, 10'h133, 10'h021, 8'h96, 1'b1, 1'b0);
    n = mdl.cbr_cnt;
    issue(dram_ctl_pkg::CMD_READ, 10'h133, 10'h021, 8'h00, 1'b1, 1'b1);
    expect_read(8'h96);
    for (i = 0; i < 60 && mdl.cbr_cnt == n; i++) @(posedge ref_clk);
    check(mdl.cbr_cnt, n + 1, "hidden refresh kind");
    check(32'(dq), 32'h96, "data kept in refresh");
    wait_ras;
    check(mdl.clash, 0, "data line clash");
  endtask : t_hidden
  // every refresh row is visited within the paced interval plus 1000 cycles
  task automatic t_cover;
    mdl.fresh = '0;
    repeat (dram_ctl_pkg::ROWS_REFRESH * STEP + 1000) @(posedge ref_clk);
    check(32'(&mdl.fresh), 32'h1, "all rows refreshed");
  endtask : t_cover
  // print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    t_reset;
    t_page;
    t_top_row_bit;
    t_refresh;
    t_hidden;
    t_cover;
    report_and_stop;
  end
endmodule : test_dram_module_page_and_refresh
